//--- test/ext_voltage_adc_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module ext_voltage_adc_sequencer_tb_top;
  import ext_volt_pkg::*;
  localparam int UNIT = 20;
  typedef struct packed { logic [7:0] data; logic irq; } row_type;
  logic            ref_clk_i     = 1'b0;
  logic            arst_n_i      = 1'b0;
  logic            ce_i          = 1'b1;
  logic            sfr_direct_i  = 1'b1;
  logic            sfr_wr_i      = 1'b0;
  logic            sfr_rd_i      = 1'b0;
  logic            adc_done_i    = 1'b0;
  logic [7:0]      sfr_addr_i    = 8'h00;
  logic [7:0]      sfr_wdata_i   = 8'h00;
  logic [7:0]      adc_data_i    = 8'h00;
  power_state_type power_state_i = FULL_POWER_STATE;
  logic [7:0]      sfr_rdata_o;
  logic            adc_start_o;
  logic            adc_irq_o;
  logic            power_irq_o;
  int              n_fail        = 0;
  int              cmp_count     = 0;
  int              cycles        = 0;
  int              n_starts      = 0;
  int              n_taken       = 0;
  int              s0;
  time             t_start;
  time             t_prev;
  logic            irq;
  logic [7:0]      last;
  logic [7:0]      regs [6]      = '{8'hD8, 8'hEC, 8'hEF, 8'hF3, 8'hF8, 8'hF9};
  row_type         rows [6]      = '{'{8'h42, 1'b0}, '{8'h43, 1'b1}, '{8'h41, 1'b0},
                                     '{8'h40, 1'b1}, '{8'h00, 1'b1}, '{8'hFF, 1'b1}};

  ext_voltage_adc_sequencer #(.UNIT_CYCLES(UNIT)) u_ext_voltage_adc_sequencer (
    .ref_clk_i     (ref_clk_i),
    .arst_n_i      (arst_n_i),
    .ce_i          (ce_i),
    .sfr_addr_i    (sfr_addr_i),
    .sfr_direct_i  (sfr_direct_i),
    .sfr_wr_i      (sfr_wr_i),
    .sfr_rd_i      (sfr_rd_i),
    .sfr_wdata_i   (sfr_wdata_i),
    .sfr_rdata_o   (sfr_rdata_o),
    .power_state_i (power_state_i),
    .adc_start_o   (adc_start_o),
    .adc_done_i    (adc_done_i),
    .adc_data_i    (adc_data_i),
    .adc_irq_o     (adc_irq_o),
    .power_irq_o   (power_irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cycles++;
    if (adc_start_o === 1'b1) begin
      n_starts++;
      t_start = $time;
    end
    if (cycles == 20000) begin
      n_fail++;
      $display("BAD run_time exp done got hang");
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    sfr_wr_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    sfr_rd_i = 1'b0;
    `CHK(nm, e, sfr_rdata_o)
    @(posedge ref_clk_i);
    #1;
  endtask

  // bench plays the converter: waits for start, answers after three cycles
  task automatic convert(input logic [7:0] d, output logic got_irq);
    int n;
    n = 0;
    while (n_starts == n_taken && n < 400) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    `CHK("adc_start", n_taken + 1, n_starts)
    n_taken = n_starts;
    repeat (3) @(posedge ref_clk_i);
    #1;
    adc_done_i = 1'b1;
    adc_data_i = d;
    @(posedge ref_clk_i);
    #1;
    adc_done_i = 1'b0;
    adc_data_i = ~d;
    got_irq = adc_irq_o;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    arst_n_i = 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00, "reset_value");
    repeat (100) @(posedge ref_clk_i);
    #1;
    `CHK("idle_starts", 0, n_starts)
    $display("test reset done");

    wr(8'hD8, 8'h04);
    rd(8'hD8, 8'h04, "go_pending");
    convert(8'h40, irq);
    `CHK("single_irq", 1'b1, irq)
    rd(8'hEF, 8'h40, "single_result");
    rd(8'hD8, 8'h00, "go_cleared");
    rd(8'hF8, 8'h00, "no_irq_flag");
    wr(8'hEF, 8'h55);
    rd(8'hEF, 8'h40, "result_ro");
    sfr_direct_i = 1'b0;
    wr(8'hF3, 8'h07);
    sfr_direct_i = 1'b1;
    rd(8'hF3, 8'h00, "indirect_wr");
    rd(8'hA0, 8'h00, "unmapped");
    rd(8'hEF, 8'h40, "result_again");
    rd(8'h73, 8'h40, "low_addr");
    $display("test single done");

    wr(8'hF3, 8'h02);
    rd(8'hF3, 8'h02, "delta_cfg");
    wr(8'hEC, 8'h08);
    rd(8'hEC, 8'h08, "enable_cfg");
    wr(8'hF9, 8'h10);
    rd(8'hF9, 8'h10, "interval_cfg");
    last = 8'h40;
    foreach (rows[i]) begin
      convert(rows[i].data, irq);
      `CHK("bg_irq", rows[i].irq, irq)
      if (rows[i].irq) last = rows[i].data;
      rd(8'hEF, last, "bg_result");
      rd(8'hF8, {4'h0, rows[i].irq, 3'h0}, "change_flag");
      `CHK("power_irq", rows[i].irq, power_irq_o)
      wr(8'hF8, 8'h00);
    end
    $display("test background done");

    wr(8'hEC, 8'h00);
    convert(8'h10, irq);
    `CHK("bg_irq_masked", 1'b1, irq)
    rd(8'hF8, 8'h08, "flag_masked");
    `CHK("power_irq_masked", 1'b0, power_irq_o)
    wr(8'hF8, 8'h08);
    rd(8'hF8, 8'h08, "flag_wr_one");
    wr(8'hF8, 8'h00);
    rd(8'hF8, 8'h00, "flag_clear");
    $display("test mask done");

    for (int s = 1; s <= 3; s++) begin
      wr(8'hF9, 8'(s << 4));
      convert(8'h10, irq);
      convert(8'h10, irq);
      t_prev = t_start;
      convert(8'h10, irq);
      `CHK("interval", 32'(UNIT << (s - 1)), 32'((t_start - t_prev) / 10))
    end
    $display("test interval done");

    power_state_i = BATTERY_POWER_STATE;
    wr(8'hD8, 8'h04);
    convert(8'h22, irq);
    `CHK("battery_single", 1'b1, irq)
    s0 = n_starts;
    repeat (200) @(posedge ref_clk_i);
    #1;
    `CHK("battery_no_bg", s0, n_starts)
    $display("test battery done");

    wr(8'hF9, 8'h00);
    power_state_i = SLEEP_POWER_STATE;
    wr(8'hD8, 8'h04);
    s0 = n_starts;
    repeat (50) @(posedge ref_clk_i);
    #1;
    `CHK("sleep_no_single", s0, n_starts)
    rd(8'hD8, 8'h04, "sleep_pending");
    power_state_i = FULL_POWER_STATE;
    convert(8'h80, irq);
    `CHK("full_single", 1'b1, irq)
    rd(8'hD8, 8'h00, "go_cleared2");
    power_state_i = SLEEP_POWER_STATE;
    wr(8'hF9, 8'h10);
    convert(8'h10, irq);
    `CHK("sleep_bg", 1'b1, irq)
    rd(8'hEF, 8'h10, "sleep_result");
    $display("test sleep done");

    ce_i = 1'b0;
    wr(8'hF3, 8'h05);
    rd(8'hF3, 8'h10, "ce_rd_frozen");
    ce_i = 1'b1;
    rd(8'hF3, 8'h02, "ce_wr_frozen");
    $display("test clock enable done");

    arst_n_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    `CHK("rst_irq", 1'b0, adc_irq_o)
    `CHK("rst_power_irq", 1'b0, power_irq_o)
    `CHK("rst_rdata", 8'h00, sfr_rdata_o)
    arst_n_i = 1'b1;
    rd(8'hEF, 8'h00, "rst_result");
    rd(8'hF8, 8'h00, "rst_flag");
    rd(8'hF9, 8'h00, "rst_interval");
    $display("test mid reset done");
    summarize();
  end
endmodule // ext_voltage_adc_sequencer_tb_top

//--- verilog/abs_delta_cmp.sv
`timescale 1ns/1ps
module abs_delta_cmp #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] sample_i,
  input  wire logic [WIDTH-1:0] baseline_i,
  input  wire logic [2:0]       delta_i,
  output logic                  over_o
);
  if (WIDTH < 3) begin : g_bad_width
    $error("abs_delta_cmp: WIDTH below 3");
  end

  function automatic logic [WIDTH-1:0] abs_diff(input logic [WIDTH-1:0] a,
                                                input logic [WIDTH-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // strictly greater than the programmed delta
  assign over_o = abs_diff(sample_i, baseline_i) > {{(WIDTH-3){1'b0}}, delta_i};
endmodule // abs_delta_cmp

//--- verilog/ext_volt_cfg.svh
// What this block does
// - writing one to start register bit 2 launches one single conversion
// - single conversion end stores result and raises the adc interrupt
// - background conversions off after reset; run only with nonzero interval
// - background interval is selected by interval register bits 5..4
// - background result differing from baseline by more than delta sets change flag
// - change flag lives in bit 3 of the power event flag register
// - enable bit 3 turns a set change flag into power event interrupt
// - full power state allows both background and single conversions
// - battery state allows single conversions, suppresses background ones
// - sleep state converts only through background mechanism
// - result register loads only when adc interrupt is raised, else holds
// - adc interrupt on background change over delta or single completion
// - adc interrupt has no pending flag bit of its own
// - registers sit in upper 128 bytes, answer direct accesses only
// - each result step is a fixed voltage increment
`ifndef EXT_VOLT_CFG_SVH
`define EXT_VOLT_CFG_SVH

`define SFR_UPPER_BASE      8'h80
`define OFS_CONV_START      8'hD8
`define OFS_EVENT_ENABLE    8'hEC
`define OFS_RESULT          8'hEF
`define OFS_DELTA_CFG       8'hF3
`define OFS_EVENT_FLAGS     8'hF8
`define OFS_INTERVAL_CFG    8'hF9

`define BIT_SINGLE_GO       2
`define BIT_CHANGE_FLAG     3
`define BIT_CHANGE_EN       3
`define DELTA_MSB           2
`define DELTA_LSB           0
`define INTERVAL_MSB        5
`define INTERVAL_LSB        4

`define RST_BYTE            8'h00
`define RESULT_LSB_UV       15300
`define INTERVAL_UNIT_US    1000
`define CLK_PERIOD_NS       10
`define INTERVAL_UNIT_CYC   ((`INTERVAL_UNIT_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- verilog/ext_volt_pkg.sv
package ext_volt_pkg;
  typedef enum logic [1:0] {
    FULL_POWER_STATE    = 2'h0,
    BATTERY_POWER_STATE = 2'h1,
    SLEEP_POWER_STATE   = 2'h2,
    UNUSED_POWER_STATE  = 2'h3
  } power_state_type;

  typedef enum logic [2:0] {
    CONV_IDLE       = 3'h1,
    CONV_SINGLE     = 3'h2,
    CONV_BACKGROUND = 3'h4
  } conv_state_type;
endpackage

//--- verilog/ext_voltage_adc_sequencer.sv
`timescale 1ns/1ps
`include "ext_volt_cfg.svh"
module ext_voltage_adc_sequencer #(
  parameter int UNIT_CYCLES = `INTERVAL_UNIT_CYC
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          ce_i,
  input  wire logic [7:0]                    sfr_addr_i,
  input  wire logic                          sfr_direct_i,
  input  wire logic                          sfr_wr_i,
  input  wire logic                          sfr_rd_i,
  input  wire logic [7:0]                    sfr_wdata_i,
  output logic      [7:0]                    sfr_rdata_o,
  input  wire ext_volt_pkg::power_state_type power_state_i,
  output logic                               adc_start_o,
  input  wire logic                          adc_done_i,
  input  wire logic [7:0]                    adc_data_i,
  output logic                               adc_irq_o,
  output logic                               power_irq_o
);
  import ext_volt_pkg::*;

  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("ext_voltage_adc_sequencer: UNIT_CYCLES below 1");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic       sfr_sel;
  logic       wr_en;
  logic       rd_en;
  // upper half, direct addressing only
  assign sfr_sel = sfr_direct_i && (sfr_addr_i >= `SFR_UPPER_BASE);
  assign wr_en   = ce_i && sfr_wr_i && sfr_sel;
  assign rd_en   = ce_i && sfr_rd_i && sfr_sel;

  logic       single_go_q;
  logic [7:0] event_enable_q;
  logic [7:0] result_q;
  logic [7:0] baseline_q;
  logic [7:0] delta_cfg_q;
  logic       change_flag_q;
  logic [7:0] interval_cfg_q;
  conv_state_type conv_q;
  logic       bg_pending_q;
  logic       bg_strobe;
  logic       change_over;
  logic       single_done;
  logic       bg_done;
  logic       irq_fire;
  logic       bg_allowed;
  logic       single_allowed;

  ////////////////////////////////////////////////////////////////////////////////
  // power state gating

  assign bg_allowed     = (power_state_i == FULL_POWER_STATE) ||
                          (power_state_i == SLEEP_POWER_STATE);
  assign single_allowed = (power_state_i == FULL_POWER_STATE) ||
                          (power_state_i == BATTERY_POWER_STATE);

  ////////////////////////////////////////////////////////////////////////////////
  // background interval and change compare

  interval_strobe #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_interval (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .select_i  (interval_cfg_q[`INTERVAL_MSB:`INTERVAL_LSB]),
    .strobe_o  (bg_strobe)
  );

  abs_delta_cmp #(
    .WIDTH (8)
  ) u_cmp (
    .sample_i   (adc_data_i),
    .baseline_i (baseline_q),
    .delta_i    (delta_cfg_q[`DELTA_MSB:`DELTA_LSB]),
    .over_o     (change_over)
  );

  assign single_done = adc_done_i && (conv_q == CONV_SINGLE);
  assign bg_done     = adc_done_i && (conv_q == CONV_BACKGROUND);
  // no pending bit for the adc interrupt itself
  assign irq_fire    = ce_i && (single_done || (bg_done && change_over));

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_enable_q <= `RST_BYTE;
      delta_cfg_q    <= `RST_BYTE;
      interval_cfg_q <= `RST_BYTE;
    end else if (wr_en) begin
      if (hit(sfr_addr_i, `OFS_EVENT_ENABLE)) begin
        event_enable_q <= sfr_wdata_i;
      end
      if (hit(sfr_addr_i, `OFS_DELTA_CFG)) begin
        delta_cfg_q <= sfr_wdata_i;
      end
      if (hit(sfr_addr_i, `OFS_INTERVAL_CFG)) begin
        interval_cfg_q <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // single start bit, set wins over self clear

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      single_go_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_en && hit(sfr_addr_i, `OFS_CONV_START) && sfr_wdata_i[`BIT_SINGLE_GO]) begin
        single_go_q <= 1'b1;
      end else if (single_done) begin
        single_go_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_q       <= CONV_IDLE;
      bg_pending_q <= 1'b0;
      adc_start_o  <= 1'b0;
    end else if (ce_i) begin
      adc_start_o <= 1'b0;
      if (bg_strobe && bg_allowed) begin
        bg_pending_q <= 1'b1;
      end else if (!bg_allowed) begin
        bg_pending_q <= 1'b0;
      end
      unique case (conv_q)
        CONV_IDLE: begin
          if (single_go_q && single_allowed) begin
            conv_q      <= CONV_SINGLE;
            adc_start_o <= 1'b1;
          end else if (bg_pending_q && bg_allowed) begin
            conv_q       <= CONV_BACKGROUND;
            adc_start_o  <= 1'b1;
            bg_pending_q <= bg_strobe;
          end
        end
        CONV_SINGLE: begin
          if (adc_done_i) begin
            conv_q <= CONV_IDLE;
          end
        end
        CONV_BACKGROUND: begin
          if (adc_done_i) begin
            conv_q <= CONV_IDLE;
          end
        end
        default: begin
          conv_q <= CONV_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result, baseline and change flag

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_q   <= `RST_BYTE;
      baseline_q <= `RST_BYTE;
    end else if (irq_fire) begin
      // raw code, fixed step per lsb
      result_q   <= adc_data_i;
      baseline_q <= adc_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      change_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (bg_done && change_over) begin
        change_flag_q <= 1'b1;
      end else if (wr_en && hit(sfr_addr_i, `OFS_EVENT_FLAGS) &&
                   !sfr_wdata_i[`BIT_CHANGE_FLAG]) begin
        change_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt outputs and read data

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adc_irq_o   <= 1'b0;
      power_irq_o <= 1'b0;
    end else if (ce_i) begin
      adc_irq_o   <= irq_fire;
      power_irq_o <= change_flag_q && event_enable_q[`BIT_CHANGE_EN];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o <= `RST_BYTE;
    end else if (rd_en) begin
      unique case (sfr_addr_i)
        `OFS_CONV_START:   sfr_rdata_o <= {5'h0, single_go_q, 2'h0};
        `OFS_EVENT_ENABLE: sfr_rdata_o <= event_enable_q;
        `OFS_RESULT:       sfr_rdata_o <= result_q;
        `OFS_DELTA_CFG:    sfr_rdata_o <= delta_cfg_q;
        `OFS_EVENT_FLAGS:  sfr_rdata_o <= {4'h0, change_flag_q, 3'h0};
        `OFS_INTERVAL_CFG: sfr_rdata_o <= interval_cfg_q;
        default:           sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_go_set;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_en && sfr_addr_i == `OFS_CONV_START && sfr_wdata_i[`BIT_SINGLE_GO] |=> single_go_q;
  endproperty
  a_go_set: assert property (p_go_set) else $error("start bit not set by write");

  property p_single_irq;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && single_done |=> adc_irq_o && result_q == $past(adc_data_i);
  endproperty
  a_single_irq: assert property (p_single_irq) else $error("single end without irq");

  property p_result_hold;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      !irq_fire |=> $stable(result_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");

  property p_bg_needs_interval;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && conv_q == CONV_IDLE ##1 conv_q == CONV_BACKGROUND
        |-> $past(bg_pending_q) && $past(bg_allowed);
  endproperty
  a_bg_needs_interval: assert property (p_bg_needs_interval) else $error("bg early");

  property p_battery_no_bg;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && power_state_i == BATTERY_POWER_STATE && conv_q == CONV_IDLE
        |=> conv_q != CONV_BACKGROUND;
  endproperty
  a_battery_no_bg: assert property (p_battery_no_bg) else $error("bg in battery");

  property p_sleep_no_single;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && power_state_i == SLEEP_POWER_STATE && conv_q == CONV_IDLE
        |=> conv_q != CONV_SINGLE;
  endproperty
  a_sleep_no_single: assert property (p_sleep_no_single) else $error("sleep single");

  property p_power_irq;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && change_flag_q && event_enable_q[`BIT_CHANGE_EN] |=> power_irq_o;
  endproperty
  a_power_irq: assert property (p_power_irq) else $error("enabled flag gave no irq");

  property p_change_flag;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && bg_done && change_over |=> change_flag_q && adc_irq_o;
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("change flag not set");

  property p_go_clears;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ce_i && single_done && !wr_en |=> !single_go_q && conv_q == CONV_IDLE;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("start bit did not clear");

  property p_baseline;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      irq_fire |=> baseline_q == $past(adc_data_i);
  endproperty
  a_baseline: assert property (p_baseline) else $error("baseline not refreshed");
endmodule // ext_voltage_adc_sequencer

//--- verilog/interval_strobe.sv
`timescale 1ns/1ps
module interval_strobe #(
  parameter int UNIT_CYCLES = 100000
) (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] select_i,
  output logic            strobe_o
);
  if (UNIT_CYCLES < 1 || UNIT_CYCLES > 100000000) begin : g_bad_unit
    $error("interval_strobe: bad UNIT_CYCLES");
  end

  function automatic logic [31:0] period_of(input logic [1:0] sel);
    period_of = 32'(UNIT_CYCLES) << (sel - 2'h1);
  endfunction

  logic [31:0] count_q;
  logic [1:0]  select_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q  <= 32'h0;
      select_q <= 2'h0;
      strobe_o <= 1'b0;
    end else if (ce_i) begin
      select_q <= select_i;
      strobe_o <= 1'b0;
      // zero selection keeps background conversions off
      if (select_i == 2'h0 || select_i != select_q) begin
        count_q <= 32'h0;
      end else if (count_q >= period_of(select_i) - 32'h1) begin
        count_q  <= 32'h0;
        strobe_o <= 1'b1;
      end else begin
        count_q <= count_q + 32'h1;
      end
    end
  end
endmodule // interval_strobe
